// file: brsc_ctrl.sv
/*
  Program flow control: program counter, branch sequencing with purge,
  conditional forms and the return stack. Top module brsc_ctrl.
  Assumes the decode stage holds an operation until busy_out is low, and
  that main-bus transfers and interrupt requests are on the same clock.
*/
`timescale 1ns/100ps
module brsc_ctrl
  import brsc_pkg::*;
#(
  parameter logic [15:0] RESET_PC = BRSC_RESET_PC,
  parameter int DEPTH = BRSC_DEPTH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic dec_valid_in,
  input wire logic [2:0] dec_op_in,
  input wire logic dec_cond_in,
  input wire logic cond_true_in,
  input wire logic [15:0] operand_in,
  input wire logic [15:0] data_pointer_reg_in,
  input wire logic int_req_in,
  input wire logic [15:0] int_vector_in,
  input wire logic stk_wr_in,
  input wire logic [15:0] stk_wr_data_in,
  input wire logic slp_wr_in,
  input wire logic [15:0] slp_wr_data_in,
  input wire logic ste_clr_in,
  output logic [15:0] program_counter_out,
  output logic fetch_en_out,
  output logic purge_out,
  output logic busy_out,
  output logic int_ack_out,
  output logic [15:0] stack_top_out,
  output logic [15:0] stack_level_pointer_out,
  output logic ste_out
);
  typedef enum logic [0:0] {ST_RUN, ST_WAIT} brsc_state_type;

  brsc_state_type state;
  logic [15:0] program_counter;
  logic [15:0] hold_addr;
  logic [15:0] next_target;
  logic [15:0] stk_top;
  logic [15:0] stk_ptr;
  logic stk_err;
  logic accept;
  logic taken;
  logic is_call;
  logic is_exit;
  logic is_ind;
  logic needs_wait;
  logic int_go;
  logic push;
  logic pop;
  logic [15:0] push_data;

  // decode of the offered operation
  assign accept = dec_valid_in && (state == ST_RUN);
  // the unused top code runs on sequentially, like code 0
  assign taken = accept && (dec_op_in != BRSC_OP_NONE) &&
                 (dec_op_in <= BRSC_OP_INT_EXIT) &&
                 (!dec_cond_in || cond_true_in);
  assign is_call = (dec_op_in == BRSC_OP_CALL_REL) ||
                   (dec_op_in == BRSC_OP_CALL_IND);
  assign is_exit = (dec_op_in == BRSC_OP_SUB_EXIT) ||
                   (dec_op_in == BRSC_OP_INT_EXIT);
  assign is_ind = (dec_op_in == BRSC_OP_JUMP_IND) ||
                  (dec_op_in == BRSC_OP_CALL_IND);
  // a taken conditional costs one evaluation cycle; indirect always costs it
  assign needs_wait = dec_cond_in || is_ind;
  // a branch in decode wins; the interrupt waits for a quiet cycle
  assign int_go = int_req_in && (state == ST_RUN) && !taken;

  // branch target selection
  always_comb begin
    next_target = program_counter;
    case (dec_op_in)
      BRSC_OP_JUMP_REL, BRSC_OP_CALL_REL: begin
        next_target = program_counter + operand_in;
      end
      BRSC_OP_JUMP_IND, BRSC_OP_CALL_IND: begin
        next_target = data_pointer_reg_in;
      end
      BRSC_OP_SUB_EXIT, BRSC_OP_INT_EXIT: begin
        next_target = stk_top;
      end
      default: begin
        next_target = program_counter;
      end
    endcase
  end

  // stack traffic: calls and interrupts push the address under fetch
  assign push = (taken && is_call) || int_go;
  assign pop = taken && is_exit;
  assign push_data = program_counter;

  brsc_stack #(
    .DEPTH(DEPTH)
  ) u_stack (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .push_in(push),
    .push_data_in(push_data),
    .pop_in(pop),
    .top_wr_in(stk_wr_in),
    .top_wr_data_in(stk_wr_data_in),
    .ptr_wr_in(slp_wr_in),
    .ptr_wr_data_in(slp_wr_data_in),
    .top_data_out(stk_top),
    .ptr_out(stk_ptr),
    .err_out(stk_err)
  );

  // sequencer: taken branches either redirect at once or wait one cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_RUN;
      hold_addr <= BRSC_ZERO_WORD;
      busy_out <= 1'b0;
    end else if (ce_in) begin
      case (state)
        ST_RUN: begin
          if (taken && needs_wait) begin
            hold_addr <= next_target;
            state <= ST_WAIT;
            busy_out <= 1'b1;
          end
        end
        ST_WAIT: begin
          state <= ST_RUN;
          busy_out <= 1'b0;
        end
        default: begin
          state <= ST_RUN;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // program counter: the address now being fetched; it spans all 16 bits,
  // the variant's memory size is decoded outside this block
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      program_counter <= RESET_PC;
      fetch_en_out <= 1'b0;
    end else if (ce_in) begin
      fetch_en_out <= 1'b1;
      if (state == ST_WAIT) begin
        program_counter <= hold_addr;
      end else if (taken && needs_wait) begin
        fetch_en_out <= 1'b0; // evaluation cycle, no fetch
      end else if (taken) begin
        program_counter <= next_target;
      end else if (int_go) begin
        program_counter <= int_vector_in;
      end else if (fetch_en_out) begin
        program_counter <= program_counter + BRSC_PC_STEP;
      end
    end
  end
  assign program_counter_out = program_counter;

  // purge squashes the word fetched behind a taken branch
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      purge_out <= 1'b0;
      int_ack_out <= 1'b0;
    end else if (ce_in) begin
      purge_out <= taken || int_go || (state == ST_WAIT);
      int_ack_out <= int_go;
    end
  end

  // stack error flag: a new error wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ste_out <= 1'b0;
    end else if (ce_in) begin
      if (stk_err) begin
        ste_out <= 1'b1;
      end else if (ste_clr_in) begin
        ste_out <= 1'b0;
      end
    end
  end

  // bus-visible copies; they trail the stack by one cycle, while an exit
  // takes its target from the live stack top, not from these copies
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stack_top_out <= BRSC_ZERO_WORD;
      stack_level_pointer_out <= BRSC_PTR_EMPTY;
    end else if (ce_in) begin
      stack_top_out <= stk_top;
      stack_level_pointer_out <= stk_ptr;
    end
  end

  // checks
  sequence s_wait_taken;
    ce_in && taken && needs_wait ##1 ce_in;
  endsequence

  sequence s_plain_rel;
    ce_in && taken && !dec_cond_in &&
    (dec_op_in == BRSC_OP_JUMP_REL || dec_op_in == BRSC_OP_CALL_REL);
  endsequence

  property p_pc_step;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && fetch_en_out && state == ST_RUN && !taken && !int_go)
      |=> (program_counter == $past(program_counter) + BRSC_PC_STEP);
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("pc did not step by one");

  property p_rel_two;
    @(posedge clk_in) disable iff (!rstn_in)
    s_plain_rel |=> purge_out && !busy_out &&
      (program_counter == $past(program_counter + operand_in));
  endproperty
  a_rel_two: assert property (p_rel_two)
    else $error("plain relative branch target or timing wrong");

  property p_wait_three;
    @(posedge clk_in) disable iff (!rstn_in)
    s_wait_taken |=> !busy_out && purge_out &&
      (program_counter == $past(next_target, 2));
  endproperty
  a_wait_three: assert property (p_wait_three)
    else $error("waited branch did not land on third cycle");

  property p_false_pass;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && accept && dec_cond_in && !cond_true_in && !int_go)
      |=> !busy_out && !purge_out;
  endproperty
  a_false_pass: assert property (p_false_pass)
    else $error("false condition stalled or purged");

  property p_call_push;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && taken && is_call && stk_ptr < BRSC_PTR_FULL)
      |=> (stk_ptr == $past(stk_ptr) + BRSC_PTR_STEP) &&
          (stk_top == $past(program_counter));
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call did not push return address");

  property p_exit_pop;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && taken && is_exit && stk_ptr != BRSC_PTR_EMPTY)
      |=> (stk_ptr == $past(stk_ptr) - BRSC_PTR_STEP);
  endproperty
  a_exit_pop: assert property (p_exit_pop)
    else $error("exit did not decrement pointer");

  property p_jump_nopush;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && taken && !is_call && !is_exit && !slp_wr_in)
      |=> $stable(stk_ptr);
  endproperty
  a_jump_nopush: assert property (p_jump_nopush)
    else $error("jump touched the stack pointer");

  property p_err_flag;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && stk_err) |=> ste_out && $stable(stk_ptr);
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("stack error not flagged or pointer moved");

  property p_int_push;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && int_go && stk_ptr < BRSC_PTR_FULL)
      |=> int_ack_out && (program_counter == $past(int_vector_in)) &&
          (stk_top == $past(program_counter));
  endproperty
  a_int_push: assert property (p_int_push)
    else $error("interrupt did not redirect or push");
endmodule // brsc_ctrl

// file: brsc_stack.sv
/*
  Shared constants for the branch and return stack control, plus the
  return_address_stack with its stack_level_pointer.
  Assumes one core clock, a clock enable from the core and an
  asynchronous active-low reset; all requests come from same-clock logic.
*/
package brsc_pkg;
  localparam int BRSC_ADDR_W = 16;
  localparam int BRSC_DEPTH = 15;
  localparam logic [15:0] BRSC_RESET_PC = 16'h0000;
  localparam logic [15:0] BRSC_PC_STEP = 16'h0001;
  localparam logic [15:0] BRSC_PTR_EMPTY = 16'h0000;
  localparam logic [15:0] BRSC_PTR_FULL = 16'h000F;
  localparam logic [15:0] BRSC_PTR_STEP = 16'h0001;
  localparam logic [15:0] BRSC_ZERO_WORD = 16'h0000;
  localparam logic [3:0] BRSC_IDX_STEP = 4'h1;
  // operation codes presented by the decode stage
  localparam logic [2:0] BRSC_OP_NONE = 3'h0;
  localparam logic [2:0] BRSC_OP_JUMP_REL = 3'h1;
  localparam logic [2:0] BRSC_OP_CALL_REL = 3'h2;
  localparam logic [2:0] BRSC_OP_JUMP_IND = 3'h3;
  localparam logic [2:0] BRSC_OP_CALL_IND = 3'h4;
  localparam logic [2:0] BRSC_OP_SUB_EXIT = 3'h5;
  localparam logic [2:0] BRSC_OP_INT_EXIT = 3'h6;
endpackage

`timescale 1ns/100ps
module brsc_stack
  import brsc_pkg::*;
#(
  parameter int DEPTH = BRSC_DEPTH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic push_in,
  input wire logic [15:0] push_data_in,
  input wire logic pop_in,
  input wire logic top_wr_in,
  input wire logic [15:0] top_wr_data_in,
  input wire logic ptr_wr_in,
  input wire logic [15:0] ptr_wr_data_in,
  output logic [15:0] top_data_out,
  output logic [15:0] ptr_out,
  output logic err_out
);
  logic [15:0] mem [DEPTH];
  logic [15:0] ptr;
  logic [3:0] idx;
  logic empty;
  logic full;
  logic in_range;

  // entries 1..15 live at mem[ptr-1]; pointer 0 means nothing stacked
  assign idx = ptr[3:0];
  assign empty = (ptr == BRSC_PTR_EMPTY);
  assign full = (ptr == BRSC_PTR_FULL);
  assign in_range = (ptr <= BRSC_PTR_FULL);
  assign ptr_out = ptr;
  assign top_data_out = (empty || !in_range) ? BRSC_ZERO_WORD :
                        mem[idx - BRSC_IDX_STEP];
  assign err_out = (push_in && full) || (pop_in && empty);

  // pointer: core push/pop outrank a bus write in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr <= BRSC_PTR_EMPTY;
    end else if (ce_in) begin
      if (push_in && !full) begin
        ptr <= ptr + BRSC_PTR_STEP;
      end else if (pop_in && !empty) begin
        ptr <= ptr - BRSC_PTR_STEP;
      end else if (ptr_wr_in && !push_in && !pop_in) begin
        // a failing push or pop still outranks the bus write
        ptr <= ptr_wr_data_in;
      end
    end
  end

  // storage; a push lands in the slot just above the old top
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= BRSC_ZERO_WORD;
      end
    end else if (ce_in) begin
      if (push_in && !full && in_range) begin
        mem[idx] <= push_data_in;
      end else if (top_wr_in && !empty && in_range && !pop_in) begin
        mem[idx - BRSC_IDX_STEP] <= top_wr_data_in;
      end
    end
  end
endmodule // brsc_stack

// file: brsc_fetch_model.sv
/*
  Stand-in for the fetch and decode pipeline: offers one op to decode.
  Assumes the bench calls offer at a falling edge while busy is low.
*/
`timescale 1ns/100ps
module brsc_fetch_model
  import brsc_pkg::*;
(
  input wire logic clk_in,
  output logic dec_valid_out,
  output logic [2:0] dec_op_out,
  output logic dec_cond_out,
  output logic cond_true_out,
  output logic [15:0] operand_out
);
  // decode idle from time zero
  initial begin
    dec_valid_out = 1'b0;
    dec_op_out = BRSC_OP_NONE;
    dec_cond_out = 1'b0;
    cond_true_out = 1'b0;
    operand_out = 16'h0000;
  end

  // released cond and operand fields flip, op returns to none, so a stale value cannot pass for a held one
  task automatic offer(input logic [2:0] op, input logic cd,
                       input logic ct, input logic [15:0] off);
    dec_valid_out = 1'b1;
    dec_op_out = op;
    dec_cond_out = cd;
    cond_true_out = ct;
    operand_out = off;
    @(posedge clk_in);
    @(negedge clk_in);
    dec_valid_out = 1'b0;
    dec_op_out = BRSC_OP_NONE;
    dec_cond_out = ~cd;
    cond_true_out = ~ct;
    operand_out = ~off;
  endtask
endmodule // brsc_fetch_model

// file: branch_and_return_stack_control_tb_top.sv
/*
  Self-checking bench for brsc_ctrl, one task per scenario.
  Assumes brsc_pkg and brsc_fetch_model are compiled first.
*/
`timescale 1ns/100ps
module branch_and_return_stack_control_tb_top
  import brsc_pkg::*;
;
  logic clk_in = 1'b0;
  logic rstn_in, ce_in, int_req, stk_wr, slp_wr, ste_clr;
  logic [15:0] dp, ivec, stk_d, slp_d;
  logic dv, dcd, dct;
  logic [2:0] dop;
  logic [15:0] opnd, pc, top, ptr;
  logic fen, purge, busy, iack, ste;
  int n_errors = 0;
  int samples_checked = 0;

  // 40 MHz core clock
  always #12.5 clk_in = ~clk_in;

  brsc_fetch_model u_fm (.clk_in(clk_in), .dec_valid_out(dv),
    .dec_op_out(dop), .dec_cond_out(dcd), .cond_true_out(dct),
    .operand_out(opnd));

  brsc_ctrl u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .dec_valid_in(dv), .dec_op_in(dop), .dec_cond_in(dcd),
    .cond_true_in(dct), .operand_in(opnd), .data_pointer_reg_in(dp),
    .int_req_in(int_req), .int_vector_in(ivec), .stk_wr_in(stk_wr),
    .stk_wr_data_in(stk_d), .slp_wr_in(slp_wr), .slp_wr_data_in(slp_d),
    .ste_clr_in(ste_clr), .program_counter_out(pc), .fetch_en_out(fen),
    .purge_out(purge), .busy_out(busy), .int_ack_out(iack),
    .stack_top_out(top), .stack_level_pointer_out(ptr), .ste_out(ste));

  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait2();
    repeat (2) @(negedge clk_in);
  endtask

  // cyc: 1 falls through, 2 plain redirect, 3 with a wait cycle
  task automatic do_op(input logic [2:0] op, input logic cd,
    input logic ct, input logic [15:0] off, input logic [15:0] tgt_in,
    input int cyc, output logic [15:0] pc0);
    logic [15:0] tgt;
    @(negedge clk_in);
    pc0 = pc;
    tgt = (op == BRSC_OP_JUMP_REL || op == BRSC_OP_CALL_REL) ?
          pc0 + off : tgt_in;
    dp = tgt_in;
    u_fm.offer(op, cd, ct, off);
    if (cyc == 1) begin
      chk(pc, pc0 + BRSC_PC_STEP);
      chk({15'h0000, purge}, 16'h0000);
    end else if (cyc == 2) begin
      chk(pc, tgt);
      chk({15'h0000, purge}, 16'h0001);
      @(negedge clk_in);
      chk(pc, tgt + BRSC_PC_STEP);
    end else begin
      chk({15'h0000, busy}, 16'h0001);
      chk({15'h0000, fen}, 16'h0000);
      @(negedge clk_in);
      chk(pc, tgt);
      chk({15'h0000, busy}, 16'h0000);
    end
  endtask

  // bus write of pointer (sel low) or top entry (sel high)
  task automatic bus(input logic top_sel, input logic [15:0] d);
    @(negedge clk_in);
    if (top_sel) stk_wr = 1'b1;
    else slp_wr = 1'b1;
    stk_d = d;
    slp_d = d;
    @(negedge clk_in);
    stk_wr = 1'b0;
    slp_wr = 1'b0;
    stk_d = ~d;
    slp_d = ~d;
    @(negedge clk_in);
  endtask

  task automatic t_seq();
    logic [15:0] p;
    @(negedge clk_in);
    chk({15'h0000, fen}, 16'h0001);
    p = pc;
    @(negedge clk_in);
    chk(pc, p + BRSC_PC_STEP);
    ce_in = 1'b0;
    @(negedge clk_in);
    chk(pc, p + BRSC_PC_STEP);
    ce_in = 1'b1;
  endtask

  task automatic t_jump();
    logic [15:0] r;
    do_op(BRSC_OP_JUMP_REL, 1'b0, 1'b0, 16'hFFF0, 16'h0000, 2, r);
    chk(ptr, BRSC_PTR_EMPTY);
    do_op(BRSC_OP_NONE, 1'b0, 1'b0, 16'h0100, 16'h0000, 1, r);
    do_op(3'h7, 1'b0, 1'b0, 16'h0100, 16'h0000, 1, r);
    do_op(BRSC_OP_JUMP_IND, 1'b0, 1'b0, 16'h0000, 16'h1234, 3, r);
    wait2();
    chk(ptr, BRSC_PTR_EMPTY);
  endtask

  task automatic t_cond();
    logic [15:0] r;
    do_op(BRSC_OP_JUMP_REL, 1'b1, 1'b1, 16'h0040, 16'h0000, 3, r);
    do_op(BRSC_OP_JUMP_REL, 1'b1, 1'b0, 16'h0040, 16'h0000, 1, r);
    do_op(BRSC_OP_CALL_IND, 1'b1, 1'b0, 16'h0000, 16'h2222, 1, r);
    wait2();
    chk(ptr, BRSC_PTR_EMPTY);
  endtask

  task automatic t_call();
    logic [15:0] r1, r2, r;
    do_op(BRSC_OP_CALL_REL, 1'b1, 1'b1, 16'h0100, 16'h0000, 3, r1);
    wait2();
    chk(ptr, 16'h0001);
    chk(top, r1);
    do_op(BRSC_OP_CALL_IND, 1'b0, 1'b0, 16'h0000, 16'h3000, 3, r2);
    wait2();
    chk(ptr, 16'h0002);
    chk(top, r2);
    do_op(BRSC_OP_SUB_EXIT, 1'b0, 1'b0, 16'h0000, r2, 2, r);
    wait2();
    chk(ptr, 16'h0001);
    chk(top, r1);
    do_op(BRSC_OP_SUB_EXIT, 1'b1, 1'b1, 16'h0000, r1, 3, r);
    wait2();
    chk(ptr, BRSC_PTR_EMPTY);
  endtask

  task automatic t_int();
    logic [15:0] p, r;
    @(negedge clk_in);
    p = pc;
    int_req = 1'b1;
    ivec = 16'h0800;
    @(negedge clk_in);
    chk({15'h0000, iack}, 16'h0001);
    chk(pc, 16'h0800);
    int_req = 1'b0;
    wait2();
    chk(top, p);
    do_op(BRSC_OP_INT_EXIT, 1'b0, 1'b0, 16'h0000, p, 2, r);
    wait2();
    chk(ptr, BRSC_PTR_EMPTY);
  endtask

  task automatic t_err();
    logic [15:0] r;
    bus(1'b0, BRSC_PTR_FULL);
    chk(ptr, BRSC_PTR_FULL);
    bus(1'b1, 16'hBEEF);
    chk(top, 16'hBEEF);
    do_op(BRSC_OP_CALL_REL, 1'b0, 1'b0, 16'h0010, 16'h0000, 2, r);
    chk({15'h0000, ste}, 16'h0001);
    chk(ptr, BRSC_PTR_FULL);
    chk(top, 16'hBEEF);
    ste_clr = 1'b1;
    @(negedge clk_in);
    ste_clr = 1'b0;
    @(negedge clk_in);
    chk({15'h0000, ste}, 16'h0000);
    bus(1'b0, BRSC_PTR_EMPTY);
    // exit kept well clear of the bus write
    do_op(BRSC_OP_SUB_EXIT, 1'b0, 1'b0, 16'h0000, 16'h0000, 2, r);
    chk({15'h0000, ste}, 16'h0001);
    chk(ptr, BRSC_PTR_EMPTY);
  endtask

  // main sequence: reset for 3 cycles, then scenarios
  initial begin
    rstn_in = 1'b0;
    ce_in = 1'b1;
    int_req = 1'b0;
    stk_wr = 1'b0;
    slp_wr = 1'b0;
    ste_clr = 1'b0;
    dp = 16'h0000;
    ivec = 16'h0000;
    stk_d = 16'h0000;
    slp_d = 16'h0000;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    rstn_in = 1'b1;
    t_seq();
    t_jump();
    t_cond();
    t_call();
    t_int();
    t_err();
    end_of_test();
  end

  // tests need about 75 cycles; cut a hang well beyond that
  initial begin
    #50us;
    n_errors++;
    end_of_test();
  end
endmodule // branch_and_return_stack_control_tb_top
